// ---- hdl/spr_top.sv ----
// How it works
// R1: size code N selects N+1 bit frames
// R2: slave with output disable never drives line
// R3: role bit 0 master, changeable only disabled
// R4: no serial transfers while port disabled
// R5: loop-back feeds transmit shifter into receiver
// R6: data read pops receive fifo, frames pushed
// R7: data write pushes transmit fifo, shifted out
// R8: narrow frames right-justified, upper bits ignored
// R9: control-word format sends low byte only
// R10: fifos keep contents while port disabled
// R11: busy while framing or transmit fifo nonempty
// R12: status bits report the four fifo flags
// R13: prescale divisor lsb forced to zero
// R14: mask bits enable interrupts, reset zero
// R15: transmit and receive fifo level interrupts
// R16: receive timeout when fifo left unread
// R17: overrun when receiving into full fifo
// R18: raw status unmasked, writes ignored
// R19: masked status and irq outputs gated
// R20: clear register clears timeout and overrun
// R21: dma control bits enable tx, rx requests
// R22: receive dma single and burst requests
// R23: bit rate is clock over divisor times (rate plus one)
// R24: dma requests drop when disabled
// R25: timeout is 32 bit periods since activity
// R26: fifos eight deep, thresholds at four
module spr_top
    import spr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic sclkOut,
    output logic frameOut_n,
    output logic serialOut,
    output logic serialOutEn_n,
    input wire logic sclkIn,
    input wire logic frameIn_n,
    input wire logic serialIn,
    output logic txLevelIrq,
    output logic rxLevelIrq,
    output logic rxTimeoutIrq,
    output logic rxOverrunIrq,
    output logic txDmaSingle,
    output logic txDmaBurst,
    output logic rxDmaSingle,
    output logic rxDmaBurst
);
    // software-visible configuration
    logic [7:0] serialRateField; // divides the prescaled clock further
    logic [1:0] clkModeBits; // phase and polarity, stored for read-back only
    logic [1:0] frameFormat; // frame format field
    logic [3:0] frameSizeSel; // data size code
    logic slaveTxDisable;
    logic roleSelect; // 0 master, 1 slave
    logic portEnable;
    logic loopbackEn;
    logic [7:0] prescaleDivisor;
    logic [3:0] irqMask;
    logic txDmaEn;
    logic rxDmaEn;
    // interrupt sources that hold state
    logic rxTimeoutRaw;
    logic rxOverrunRaw;
    // fifos
    logic [15:0] txMem [8];
    logic [15:0] rxMem [8];
    logic [2:0] txWrPtr;
    logic [2:0] txRdPtr;
    logic [2:0] rxWrPtr;
    logic [2:0] rxRdPtr;
    logic [3:0] txCount;
    logic [3:0] rxCount;
    // serial engine
    spr_state_t state;
    logic [15:0] txShift;
    logic [15:0] rxShift;
    logic [3:0] bitCnt;
    logic [15:0] halfCnt;
    logic sclkInPrev; // last sampled slave clock
    logic [6:0] toCnt; // half periods since last receive fifo activity

    // bus decode: a transfer completes on the edge where pready is seen high
    logic busDone;
    logic busWrite;
    logic busRead;
    assign busDone = psel && penable && pready;
    assign busWrite = busDone && pwrite;
    assign busRead = busDone && !pwrite;

    // fifo flags
    logic txEmpty;
    logic txFull;
    logic rxEmpty;
    logic rxFull;
    assign txEmpty = (txCount == 4'h0);
    assign txFull = (txCount == SPR_FIFO_DEPTH); // R26
    assign rxEmpty = (rxCount == 4'h0);
    assign rxFull = (rxCount == SPR_FIFO_DEPTH); // R26

    // fifo strobes; a write to a full transmit fifo is dropped
    logic txPush;
    logic txPop;
    logic rxPush;
    logic rxPop;
    logic engineLoad;
    assign txPush = busWrite && (paddr == SPR_OFS_DATA) && !txFull; // R7
    assign rxPop = busRead && (paddr == SPR_OFS_DATA) && !rxEmpty; // R6
    assign rxPush = (state == SPR_DONE) && !rxFull; // R6
    assign txPop = engineLoad && !txEmpty;

    // frame length, output bit and loop-back source
    logic [4:0] frameBits;
    logic [3:0] lastIdx;
    logic outBit;
    logic inBit;
    assign frameBits = spr_frame_bits(frameSizeSel); // R1
    assign lastIdx = frameBits[3:0] - 4'h1;
    assign outBit = txShift[lastIdx]; // R8
    assign inBit = loopbackEn ? outBit : serialIn; // R5

    // half bit period: divisor * (1 + rate) / 2; divisor is always even
    logic [15:0] halfLen;
    logic halfTick;
    assign halfLen = 16'(prescaleDivisor[7:1]) * (16'(serialRateField) + 16'h0001); // R23
    assign halfTick = (halfCnt + 16'h0001) >= halfLen;

    // sampling and shifting edges for both roles
    logic sampleEdge;
    logic shiftEdge;
    always_comb begin
        if (roleSelect) begin
            sampleEdge = sclkIn && !sclkInPrev;
            shiftEdge = !sclkIn && sclkInPrev;
        end else begin
            sampleEdge = halfTick && !sclkOut;
            shiftEdge = halfTick && sclkOut;
        end
    end

    // master load waits for data; slave load waits for its frame select
    always_comb begin
        engineLoad = 1'b0;
        if (state == SPR_IDLE && portEnable) begin // R4
            engineLoad = roleSelect ? !frameIn_n : !txEmpty;
        end
    end

    // raw and masked interrupt views
    logic [3:0] rawIrq;
    logic [3:0] maskedIrq;
    always_comb begin
        rawIrq = 4'h0;
        rawIrq[SPR_IRQ_TXL] = (txCount <= SPR_FIFO_HALF); // R15
        rawIrq[SPR_IRQ_RXL] = (rxCount >= SPR_FIFO_HALF); // R15
        rawIrq[SPR_IRQ_TMO] = rxTimeoutRaw;
        rawIrq[SPR_IRQ_OVR] = rxOverrunRaw;
        maskedIrq = rawIrq & irqMask; // R19
    end

    logic busyFlag;
    assign busyFlag = (state != SPR_IDLE) || !txEmpty; // R11

    // read mux; reserved bits and unmapped offsets read zero
    logic [15:0] readVal;
    always_comb begin
        case (paddr)
            SPR_OFS_CTRL0: readVal = {serialRateField, clkModeBits, frameFormat, frameSizeSel};
            SPR_OFS_CTRL1: readVal = {12'h000, slaveTxDisable, roleSelect, portEnable, loopbackEn};
            SPR_OFS_DATA: readVal = rxMem[rxRdPtr]; // R6
            SPR_OFS_STATUS: readVal = {11'h000, busyFlag, rxFull, !rxEmpty, !txFull, txEmpty}; // R12
            SPR_OFS_PRESCALE: readVal = {8'h00, prescaleDivisor};
            SPR_OFS_IMASK: readVal = {12'h000, irqMask}; // R14
            SPR_OFS_IRAW: readVal = {12'h000, rawIrq}; // R18
            SPR_OFS_IMASKED: readVal = {12'h000, maskedIrq}; // R19
            SPR_OFS_DMACTL: readVal = {14'h0000, txDmaEn, rxDmaEn};
            default: readVal = 16'h0000;
        endcase
    end

    // bus slave: one wait state, read data captured with pready
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= 1'b0; // unmapped offsets answer without error
            if (psel && penable && !pready && !pwrite) begin
                prdata <= {16'h0000, readVal};
            end
        end
    end

    // control registers written by software
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {serialRateField, clkModeBits, frameFormat, frameSizeSel} <= SPR_CTRL0_RST;
            slaveTxDisable <= 1'b0;
            roleSelect <= 1'b0; // R3
            portEnable <= 1'b0;
            loopbackEn <= 1'b0;
            prescaleDivisor <= SPR_PRESCALE_RST;
            irqMask <= SPR_IMASK_RST; // R14
            txDmaEn <= SPR_DMACTL_RST[SPR_DMA_TX]; // R21
            rxDmaEn <= SPR_DMACTL_RST[SPR_DMA_RX]; // R21
        end else if (busWrite) begin
            case (paddr)
                SPR_OFS_CTRL0: begin
                    {serialRateField, clkModeBits, frameFormat, frameSizeSel} <= pwdata[15:0];
                end
                SPR_OFS_CTRL1: begin
                    slaveTxDisable <= pwdata[SPR_CR1_SOD];
                    portEnable <= pwdata[SPR_CR1_ENABLE];
                    loopbackEn <= pwdata[SPR_CR1_LOOP];
                    // role is frozen while the port runs
                    if (!portEnable) begin
                        roleSelect <= pwdata[SPR_CR1_ROLE]; // R3
                    end
                end
                SPR_OFS_PRESCALE: prescaleDivisor <= {pwdata[7:1], 1'b0}; // R13
                SPR_OFS_IMASK: irqMask <= pwdata[3:0]; // R14
                SPR_OFS_DMACTL: begin
                    txDmaEn <= pwdata[SPR_DMA_TX]; // R21
                    rxDmaEn <= pwdata[SPR_DMA_RX]; // R21
                end
                default: begin
                    // raw, masked and status views ignore writes
                end
            endcase
        end
    end

    // transmit fifo; contents survive a disable so software can preload
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            txWrPtr <= 3'h0;
            txRdPtr <= 3'h0;
            txCount <= 4'h0;
        end else begin
            if (txPush) begin
                txMem[txWrPtr] <= pwdata[15:0]; // R7
                txWrPtr <= txWrPtr + 3'h1;
            end
            if (txPop) begin
                txRdPtr <= txRdPtr + 3'h1;
            end
            txCount <= txCount + 4'(txPush) - 4'(txPop); // R10
        end
    end

    // receive fifo; a frame arriving while full is lost
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rxWrPtr <= 3'h0;
            rxRdPtr <= 3'h0;
            rxCount <= 4'h0;
        end else begin
            if (rxPush) begin
                rxMem[rxWrPtr] <= rxShift; // R6
                rxWrPtr <= rxWrPtr + 3'h1;
            end
            if (rxPop) begin
                rxRdPtr <= rxRdPtr + 3'h1; // R6
            end
            rxCount <= rxCount + 4'(rxPush) - 4'(rxPop); // R10
        end
    end

    // free-running half bit timer, also paces the receive timeout
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            halfCnt <= 16'h0000;
            sclkInPrev <= 1'b0;
        end else begin
            // restart on load so the far side gets a full half period to drive its first bit
            halfCnt <= (halfTick || engineLoad) ? 16'h0000 : halfCnt + 16'h0001; // R23
            sclkInPrev <= sclkIn;
        end
    end

    // serial engine
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= SPR_IDLE;
            txShift <= 16'h0000;
            rxShift <= 16'h0000;
            bitCnt <= 4'h0;
            sclkOut <= 1'b0;
            frameOut_n <= 1'b1;
        end else begin
            case (state)
                SPR_IDLE: begin
                    sclkOut <= 1'b0;
                    if (engineLoad) begin
                        // control-word format sends the low byte only
                        if (txEmpty) begin
                            txShift <= 16'h0000;
                        end else if (frameFormat == SPR_FRF_CTRLWORD) begin
                            txShift <= {8'h00, txMem[txRdPtr][7:0]}; // R9
                        end else begin
                            txShift <= txMem[txRdPtr]; // R7
                        end
                        // cleared so short frames land right-justified
                        rxShift <= 16'h0000; // R8
                        bitCnt <= 4'h0;
                        frameOut_n <= roleSelect;
                        state <= SPR_SHIFT;
                    end
                end
                SPR_SHIFT: begin
                    if (!portEnable || (roleSelect && frameIn_n)) begin
                        // disable or lost select aborts the frame
                        state <= SPR_IDLE; // R4
                        frameOut_n <= 1'b1;
                        sclkOut <= 1'b0;
                    end else begin
                        if (!roleSelect && halfTick) begin
                            sclkOut <= !sclkOut;
                        end
                        if (sampleEdge) begin
                            rxShift <= {rxShift[14:0], inBit}; // R5
                        end
                        if (shiftEdge) begin
                            txShift <= {txShift[14:0], 1'b0};
                            bitCnt <= bitCnt + 4'h1;
                            if (bitCnt == lastIdx) begin
                                state <= SPR_DONE; // R1
                            end
                        end
                    end
                end
                SPR_DONE: begin
                    frameOut_n <= 1'b1;
                    state <= SPR_IDLE;
                end
                default: state <= SPR_IDLE;
            endcase
        end
    end

    // serial output pin; a muted slave releases the line
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            serialOut <= 1'b0;
            serialOutEn_n <= 1'b1;
        end else begin
            serialOut <= (state == SPR_SHIFT) && outBit;
            serialOutEn_n <= !(portEnable && (!roleSelect ||
                (!slaveTxDisable && state == SPR_SHIFT))); // R2
        end
    end

    // receive timeout counter, restarted by any receive fifo activity
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            toCnt <= 7'h00;
        end else if (rxPush || rxPop || rxEmpty) begin
            toCnt <= 7'h00; // R25
        end else if (halfTick && toCnt != SPR_TIMEOUT_HALVES) begin
            toCnt <= toCnt + 7'h01; // R25
        end
    end

    // sticky sources; a new event wins over a clear in the same cycle
    logic toSet;
    logic ovrSet;
    logic clrWrite;
    assign toSet = !rxEmpty && (toCnt == SPR_TIMEOUT_HALVES); // R16
    assign ovrSet = (state == SPR_DONE) && rxFull; // R17
    assign clrWrite = busWrite && (paddr == SPR_OFS_ICLR);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rxTimeoutRaw <= 1'b0;
            rxOverrunRaw <= 1'b0;
        end else begin
            if (toSet) begin
                rxTimeoutRaw <= 1'b1; // R16
            end else if (clrWrite && pwdata[SPR_IRQ_TMO]) begin
                rxTimeoutRaw <= 1'b0; // R20
            end
            if (ovrSet) begin
                rxOverrunRaw <= 1'b1; // R17
            end else if (clrWrite && pwdata[SPR_IRQ_OVR]) begin
                rxOverrunRaw <= 1'b0; // R20
            end
        end
    end

    // interrupt outputs, one cycle behind the masked view
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {txLevelIrq, rxLevelIrq, rxTimeoutIrq, rxOverrunIrq} <= 4'h0;
        end else begin
            {txLevelIrq, rxLevelIrq, rxTimeoutIrq, rxOverrunIrq} <= maskedIrq; // R19
        end
    end

    // dma requests follow fifo levels, gated by enables
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {txDmaSingle, txDmaBurst, rxDmaSingle, rxDmaBurst} <= 4'h0;
        end else begin
            txDmaSingle <= portEnable && txDmaEn && !txFull; // R24
            txDmaBurst <= portEnable && txDmaEn && (txCount <= SPR_FIFO_HALF); // R24
            rxDmaSingle <= portEnable && rxDmaEn && !rxEmpty; // R22
            rxDmaBurst <= portEnable && rxDmaEn && (rxCount >= SPR_FIFO_HALF); // R22
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_frame_start;
        (state == SPR_IDLE) ##1 (state == SPR_SHIFT);
    endsequence

    a_prescale_even: assert property ( // R13
        busWrite && paddr == SPR_OFS_PRESCALE |=> prescaleDivisor == {$past(pwdata[7:1]), 1'b0})
        else $error("prescale divisor lsb not cleared");
    a_role_frozen: assert property ( // R3
        portEnable |=> $stable(roleSelect))
        else $error("role changed while enabled");
    a_idle_disabled: assert property ( // R4
        !portEnable && state == SPR_IDLE |=> state == SPR_IDLE)
        else $error("frame started while disabled");
    a_slave_muted: assert property ( // R2
        (roleSelect && slaveTxDisable)[*2] |-> serialOutEn_n)
        else $error("muted slave drives serial line");
    a_master_frame: assert property ( // R7
        s_frame_start ##0 !roleSelect |-> !frameOut_n && $past(txCount) != 4'h0)
        else $error("master frame without data or select");
    a_overrun_set: assert property ( // R17
        state == SPR_DONE && rxFull |=> rxOverrunRaw && rxCount == SPR_FIFO_DEPTH)
        else $error("overrun not flagged");
    a_timeout_clear: assert property ( // R20
        clrWrite && pwdata[SPR_IRQ_TMO] && !toSet |=> !rxTimeoutRaw)
        else $error("timeout not cleared");
    a_irq_masked: assert property ( // R19
        !irqMask[SPR_IRQ_OVR] [*2] |-> !rxOverrunIrq)
        else $error("masked overrun reaches output");
    a_dma_disabled: assert property ( // R24
        !portEnable |=> !(txDmaSingle || txDmaBurst || rxDmaSingle || rxDmaBurst))
        else $error("dma request while disabled");
    a_rx_push: assert property ( // R6
        state == SPR_DONE && !rxFull && !rxPop |=> rxCount == $past(rxCount) + 4'h1)
        else $error("received frame not stored");
    a_fifo_kept: assert property ( // R10
        !portEnable && state == SPR_IDLE && !txPush |=> $stable(txCount))
        else $error("transmit fifo changed while disabled");
endmodule

// ---- hdl/spr_pkg.sv ----
package spr_pkg;
    // register byte offsets on the peripheral bus
    localparam logic [11:0] SPR_OFS_CTRL0 = 12'h000;
    localparam logic [11:0] SPR_OFS_CTRL1 = 12'h004;
    localparam logic [11:0] SPR_OFS_DATA = 12'h008;
    localparam logic [11:0] SPR_OFS_STATUS = 12'h00C;
    localparam logic [11:0] SPR_OFS_PRESCALE = 12'h010;
    localparam logic [11:0] SPR_OFS_IMASK = 12'h014;
    localparam logic [11:0] SPR_OFS_IRAW = 12'h018;
    localparam logic [11:0] SPR_OFS_IMASKED = 12'h01C;
    localparam logic [11:0] SPR_OFS_ICLR = 12'h020;
    localparam logic [11:0] SPR_OFS_DMACTL = 12'h024;

    // control secondary field positions
    localparam int SPR_CR1_LOOP = 0;
    localparam int SPR_CR1_ENABLE = 1;
    localparam int SPR_CR1_ROLE = 2;
    localparam int SPR_CR1_SOD = 3;
    // interrupt bit positions, shared by mask, raw, masked and clear views
    localparam int SPR_IRQ_OVR = 0;
    localparam int SPR_IRQ_TMO = 1;
    localparam int SPR_IRQ_RXL = 2;
    localparam int SPR_IRQ_TXL = 3;
    // dma control field positions
    localparam int SPR_DMA_RX = 0;
    localparam int SPR_DMA_TX = 1;

    // reset values
    localparam logic [15:0] SPR_CTRL0_RST = 16'h0000;
    localparam logic [7:0] SPR_PRESCALE_RST = 8'h00;
    localparam logic [3:0] SPR_IMASK_RST = 4'h0;
    localparam logic [1:0] SPR_DMACTL_RST = 2'h0;

    // fifo geometry and watermark
    localparam logic [3:0] SPR_FIFO_DEPTH = 4'h8;
    localparam logic [3:0] SPR_FIFO_HALF = 4'h4;
    // frame format code of the three-wire control-word format
    localparam logic [1:0] SPR_FRF_CTRLWORD = 2'h2;
    // receive timeout in serial bit periods, counted as half periods
    localparam int SPR_TIMEOUT_BITS = 32;
    localparam logic [6:0] SPR_TIMEOUT_HALVES = 7'(2 * SPR_TIMEOUT_BITS);

    // serial engine states
    typedef enum logic [2:0] {
        SPR_IDLE = 3'b001,
        SPR_SHIFT = 3'b010,
        SPR_DONE = 3'b100
    } spr_state_t;

    // frame length in bits from the size code; codes below 3 are undefined
    function automatic logic [4:0] spr_frame_bits(input logic [3:0] code);
        return {1'b0, code} + 5'h01;
    endfunction
endpackage

// ---- sim/spr_peer.sv ----
// far-side slave on the serial link: samples on rising, drives on falling, msb first
module spr_peer (
    input wire logic clk,
    input wire logic sclk,
    input wire logic frame_n,
    input wire logic mosi,
    input wire logic [4:0] bits,
    input wire logic [15:0] reply,
    output logic miso,
    output logic [15:0] got
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sclkQ = 1'b0; // link clock seen last cycle
    logic selQ = 1'b1; // frame select seen last cycle
    logic [4:0] idx = 5'h0; // reply bit now on the line
    initial miso = 1'b0;
    initial got = 16'h0000;
    // edges are seen one cycle late, so half periods must exceed one clock
    always @(posedge clk) begin
        sclkQ <= sclk;
        selQ <= frame_n;
        if (frame_n) begin
            miso <= ~miso; // unselected: the line toggles every cycle
        end else if (selQ) begin
            idx <= bits - 5'h1;
            miso <= reply[bits - 5'h1];
        end else if (sclk && !sclkQ) begin
            got <= {got[14:0], mosi};
        end else if (!sclk && sclkQ && idx != 5'h0) begin
            idx <= idx - 5'h1;
            miso <= reply[idx - 5'h1];
        end
    end
endmodule

// ---- sim/sync_serial_port_regs_test.sv ----
module sync_serial_port_regs_test;
    import spr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic noted = 1'b0; // current read is checked by the watcher
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic frameIn_n = 1'b1;
    logic [31:0] prdata, rdVal, p;
    logic [31:0] seed = 32'h8d0b_0537;
    logic pready, serialOut, serialOutEn_n, sclkOut, frameOut_n, serialIn;
    logic [3:0] irq, dma;
    logic [15:0] reply = 16'h0000;
    logic [15:0] peerGot;
    logic [15:0] w[8];
    logic [3:0] code[4] = '{4'h3, 4'h7, 4'hF, 4'hF};
    logic [1:0] fmt[4] = '{2'h0, 2'h0, 2'h0, 2'h2};
    logic [31:0] expQ[$]; // expected read data, oldest first
    int error_cnt = 0;
    int total_checks = 0;
    int cyc = 0;
    int hi = 0;
    always #25 clk = ~clk;
    spr_top u_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
        .sclkOut(sclkOut), .frameOut_n(frameOut_n), .serialOut(serialOut),
        .serialOutEn_n(serialOutEn_n), .sclkIn(1'b0), .frameIn_n(frameIn_n),
        .serialIn(serialIn), .txLevelIrq(irq[3]), .rxLevelIrq(irq[2]),
        .rxTimeoutIrq(irq[1]), .rxOverrunIrq(irq[0]), .txDmaSingle(dma[3]),
        .txDmaBurst(dma[2]), .rxDmaSingle(dma[1]), .rxDmaBurst(dma[0]));
    spr_peer u_peer (.clk(clk), .sclk(sclkOut), .frame_n(frameOut_n), .mosi(serialOut),
        .bits(5'h10), .reply(reply), .miso(serialIn), .got(peerGot));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // one apb transfer, held until pready is seen high at a rising edge
    task automatic apb(input logic wt, input logic [11:0] a, input logic [31:0] d,
            input logic note);
        int n;
        n = 0;
        if (!wt && note) expQ.push_back(d);
        @(posedge clk); // idle cycle so no signal is driven twice in one step
        noted <= note;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wt;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) error_cnt++;
        rdVal = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, e, 1'b1);
    endtask
    // poll status without noting, until the port is no longer busy
    task automatic idle_wait();
        int n;
        n = 0;
        do begin
            apb(1'b0, SPR_OFS_STATUS, 32'h0000_0000, 1'b0);
            n++;
        end while (rdVal[4] !== 1'b0 && n < 400);
    endtask
    // watcher: every noted read is matched against the oldest expectation
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && noted) begin
            chk(prdata, expQ.pop_front());
        end
    end
    // each high phase of the link clock lasts divisor/2*(rate+1) = 4 cycles
    always @(posedge clk) begin
        if (sclkOut === 1'b1) begin
            hi++;
        end else if (hi != 0) begin
            chk(32'(hi), 32'h0000_0004);
            hi = 0;
        end
    end
    // a hang is cut short well past the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            stop_test();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(SPR_OFS_STATUS, 32'h0000_0003);
        rd(SPR_OFS_IMASK, 32'h0000_0000);
        rd(SPR_OFS_DMACTL, 32'h0000_0000);
        rd(SPR_OFS_IMASKED, 32'h0000_0000);
        wr(SPR_OFS_IRAW, 32'h0000_000F);
        rd(SPR_OFS_IRAW, 32'h0000_0008);
        rd(12'h028, 32'h0000_0000); // unmapped place reads zero
        p = rnd() & 32'h0000_00FF;
        wr(SPR_OFS_PRESCALE, p | 32'h0000_0001);
        rd(SPR_OFS_PRESCALE, p & 32'h0000_00FE);
        wr(SPR_OFS_PRESCALE, 32'h0000_0004);
        wr(SPR_OFS_IMASK, 32'h0000_0008);
        rd(SPR_OFS_IMASKED, 32'h0000_0008);
        chk(32'(irq), 32'h0000_0008);
        // loop-back frames, preloaded while disabled, several sizes and formats
        for (int i = 0; i < 4; i++) begin
            w[0] = 16'(rnd());
            wr(SPR_OFS_CTRL0, {16'h0000, 8'h01, 2'b00, fmt[i], code[i]});
            wr(SPR_OFS_DATA, {16'h0000, w[0]});
            rd(SPR_OFS_STATUS, 32'h0000_0012);
            wr(SPR_OFS_CTRL1, 32'h0000_0003);
            idle_wait();
            rd(SPR_OFS_STATUS, 32'h0000_0007);
            rd(SPR_OFS_DATA, fmt[i] == 2'h2 ? 32'(w[0][7:0])
                : 32'(w[0] & ~(16'hFFFF << (code[i] + 1))));
            wr(SPR_OFS_CTRL1, 32'h0000_0000);
        end
        // master without loop-back: the far side answers
        reply = 16'(rnd());
        w[0] = 16'(rnd());
        wr(SPR_OFS_CTRL0, 32'h0000_010F);
        wr(SPR_OFS_DATA, {16'h0000, w[0]});
        wr(SPR_OFS_CTRL1, 32'h0000_0002);
        wr(SPR_OFS_CTRL1, 32'h0000_0006);
        rd(SPR_OFS_CTRL1, 32'h0000_0002);
        idle_wait();
        chk(32'(peerGot), 32'(w[0]));
        rd(SPR_OFS_DATA, 32'(reply));
        // nine frames into an eight-deep fifo, then left unread
        wr(SPR_OFS_CTRL1, 32'h0000_0001);
        wr(SPR_OFS_IMASK, 32'h0000_000F);
        wr(SPR_OFS_DMACTL, 32'h0000_0003);
        for (int i = 0; i < 8; i++) begin
            w[i] = 16'(rnd());
            wr(SPR_OFS_DATA, {16'h0000, w[i]});
        end
        rd(SPR_OFS_STATUS, 32'h0000_0010);
        wr(SPR_OFS_CTRL1, 32'h0000_0003);
        wr(SPR_OFS_DATA, 32'h0000_5A5A);
        idle_wait();
        repeat (300) @(posedge clk);
        rd(SPR_OFS_STATUS, 32'h0000_000F);
        rd(SPR_OFS_IRAW, 32'h0000_000F);
        rd(SPR_OFS_IMASKED, 32'h0000_000F);
        chk(32'(irq), 32'h0000_000F);
        chk(32'(dma), 32'h0000_000F);
        wr(SPR_OFS_ICLR, 32'h0000_0001);
        rd(SPR_OFS_IRAW, 32'h0000_000E);
        rd(SPR_OFS_DATA, 32'(w[0]));
        wr(SPR_OFS_ICLR, 32'h0000_0002);
        rd(SPR_OFS_IRAW, 32'h0000_000C);
        wr(SPR_OFS_CTRL1, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk(32'(dma), 32'h0000_0000);
        for (int i = 1; i < 8; i++) rd(SPR_OFS_DATA, 32'(w[i]));
        rd(SPR_OFS_STATUS, 32'h0000_0003);
        // slave selected from outside, output disable set then cleared
        wr(SPR_OFS_CTRL1, 32'h0000_000C);
        wr(SPR_OFS_CTRL1, 32'h0000_000E);
        frameIn_n <= 1'b0;
        repeat (4) @(posedge clk);
        chk(32'(serialOutEn_n), 32'h0000_0001);
        wr(SPR_OFS_CTRL1, 32'h0000_0006);
        repeat (4) @(posedge clk);
        chk(32'(serialOutEn_n), 32'h0000_0000);
        frameIn_n <= 1'b1;
        repeat (4) @(posedge clk);
        stop_test();
    end
endmodule
